// ===== verilog/phy_regs_pkg.sv
`default_nettype none
package phy_regs_pkg;

  // Register indexes on the management bus
  localparam logic [4:0] LOCAL_NP_ADDR   = 5'h07;
  localparam logic [4:0] PARTNER_NP_ADDR = 5'h08;
  localparam logic [4:0] RX_TALLY_ADDR   = 5'h15;
  localparam logic [4:0] INTR_ADDR       = 5'h1B;
  localparam logic [4:0] PHY_CTRL_ADDR   = 5'h1F;

  // Outgoing next-page word fields
  localparam int NP_MORE_BIT  = 15;
  localparam int NP_MSGPG_BIT = 13;
  localparam int NP_ACK2_BIT  = 12;
  localparam int NP_TOGL_BIT  = 11;
  localparam int NP_MSG_MSB   = 10;
  localparam logic [15:0] LOCAL_NP_RESET   = 16'h2001;
  localparam logic [15:0] LOCAL_NP_WMASK   = 16'hB7FF;
  localparam logic [15:0] PARTNER_NP_RESET = 16'h0000;
  localparam logic [15:0] RX_TALLY_RESET   = 16'h0000;
  localparam logic [15:0] RX_TALLY_MAX     = 16'hFFFF;

  // Interrupt register: enables in the high byte, events in the low byte
  localparam int INTR_EN_LSB   = 8;
  localparam int EV_JABBER     = 7;
  localparam int EV_RX_ERR     = 6;
  localparam int EV_PAGE       = 5;
  localparam int EV_PD_FAULT   = 4;
  localparam int EV_LP_ACK     = 3;
  localparam int EV_LINK_DOWN  = 2;
  localparam int EV_REM_FAULT  = 1;
  localparam int EV_LINK_UP    = 0;
  localparam logic [7:0] INTR_EN_RESET = 8'h00;
  localparam logic [7:0] EVENT_RESET   = 8'h00;

  // Control register: interrupt pin polarity
  localparam int INTR_LEVEL_BIT = 9;
  localparam logic INTR_LEVEL_RESET = 1'b0;

  // Management frame timing in MDC bits
  localparam logic [5:0] PREAMBLE_BITS = 6'd32;
  localparam logic [4:0] HDR_BITS      = 5'd12;
  localparam logic [4:0] DATA_BITS     = 5'd16;
  localparam logic [1:0] OP_READ       = 2'b10;
  localparam logic [1:0] OP_WRITE      = 2'b01;

  // Decoded management access, one cycle per strobe
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } mgmt_req_type;

  // Line events from the transceiver core, one-cycle pulses
  typedef struct packed {
    logic jabber;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } link_evt_type;

endpackage
`default_nettype wire

// ===== verilog/mgmt_serial.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_serial #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // Serial management pins
  input  wire logic                       mdc,
  input  wire logic                       mdio_in,
  output logic                            mdio_out,
  output logic                            mdio_oe,
  // Register access
  output phy_regs_pkg::mgmt_req_type      req,
  input  wire logic [15:0]                rdata
);
  import phy_regs_pkg::*;

  typedef enum logic [4:0] {
    ST_PRE   = 5'b00001,
    ST_START = 5'b00010,
    ST_HDR   = 5'b00100,
    ST_TA    = 5'b01000,
    ST_DATA  = 5'b10000
  } ser_state_type;

  ser_state_type state_q, state_d;
  logic [2:0]    mdc_q, mdc_d;
  logic [1:0]    mdio_q, mdio_d;
  logic [5:0]    pre_q, pre_d;
  logic [4:0]    cnt_q, cnt_d;
  logic [15:0]   sh_q, sh_d;
  logic          is_rd_q, is_rd_d;
  logic          out_q, out_d;
  logic          oe_q, oe_d;
  mgmt_req_type  req_q, req_d;
  logic          rise;
  logic          bit_in;
  logic [11:0]   hdr;

  // Pins pass two flops; the third MDC flop only feeds the edge detect
  assign rise   = mdc_q[1] & ~mdc_q[2];
  assign bit_in = mdio_q[1];
  assign hdr    = {sh_q[10:0], bit_in};

  // Frame decode and read-data shifting
  always_comb begin
    mdc_d   = {mdc_q[1:0], mdc};
    mdio_d  = {mdio_q[0], mdio_in};
    state_d = state_q;
    pre_d   = pre_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    is_rd_d = is_rd_q;
    out_d   = out_q;
    oe_d    = oe_q;
    req_d   = '0;
    req_d.addr = req_q.addr;
    if (req_q.rd) begin
      sh_d = rdata;                        // Capture before read side effects
    end
    if (rise) begin
      case (state_q)
        ST_PRE: begin
          if (bit_in) begin
            pre_d = (pre_q == PREAMBLE_BITS) ? pre_q : pre_q + 6'd1;
          end else begin
            state_d = (pre_q == PREAMBLE_BITS) ? ST_START : ST_PRE;
            pre_d   = 6'd0;
          end
        end
        ST_START: begin
          state_d = bit_in ? ST_HDR : ST_PRE;
          cnt_d   = 5'd0;
        end
        ST_HDR: begin
          sh_d  = {sh_q[14:0], bit_in};
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == HDR_BITS - 5'd1) begin
            cnt_d      = 5'd0;
            req_d.addr = hdr[4:0];
            is_rd_d    = (hdr[11:10] == OP_READ);
            if (hdr[9:5] == PHY_ADDR && (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
              state_d  = ST_TA;
              req_d.rd = (hdr[11:10] == OP_READ);
            end else begin
              state_d = ST_PRE;
            end
          end
        end
        ST_TA: begin
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == 5'd0) begin
            oe_d  = is_rd_q;               // Drive zero in the second turnaround bit
            out_d = 1'b0;
          end else begin
            state_d = ST_DATA;
            cnt_d   = 5'd0;
            if (is_rd_q) begin
              out_d = sh_q[15];
              sh_d  = {sh_q[14:0], 1'b0};
            end
          end
        end
        ST_DATA: begin
          cnt_d = cnt_q + 5'd1;
          if (is_rd_q) begin
            out_d = sh_q[15];
            sh_d  = {sh_q[14:0], 1'b0};
          end else begin
            sh_d = {sh_q[14:0], bit_in};
          end
          if (cnt_q == DATA_BITS - 5'd1) begin
            state_d = ST_PRE;
            oe_d    = 1'b0;
            out_d   = 1'b0;
            pre_d   = 6'd0;
            if (!is_rd_q) begin
              req_d.wr    = 1'b1;
              req_d.wdata = {sh_q[14:0], bit_in};
            end
          end
        end
        default: state_d = ST_PRE;
      endcase
    end
    if (srst) begin
      state_d = ST_PRE;
      mdc_d   = 3'b000;
      mdio_d  = 2'b00;
      pre_d   = 6'd0;
      cnt_d   = 5'd0;
      sh_d    = 16'h0000;
      is_rd_d = 1'b0;
      out_d   = 1'b0;
      oe_d    = 1'b0;
      req_d   = '0;
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    state_q <= state_d;
    mdc_q   <= mdc_d;
    mdio_q  <= mdio_d;
    pre_q   <= pre_d;
    cnt_q   <= cnt_d;
    sh_q    <= sh_d;
    is_rd_q <= is_rd_d;
    out_q   <= out_d;
    oe_q    <= oe_d;
    req_q   <= req_d;
  end

  assign mdio_out = out_q;
  assign mdio_oe  = oe_q;
  assign req      = req_q;

endmodule // mgmt_serial
`default_nettype wire

// ===== verilog/phy_nextpage_irq_regs.sv
// Operation
// (R1) Ack-2 bit 7.12 is writable, one means local station complies, resets zero.
// (R2) Toggle bit 7.11 is read-only, follows last sent page toggle, resets zero.
// (R3) Message field 7.10:0 is writable, eleven bits, default value 001.
// (R4) Partner word readable; 8.15 more pages, 8.13 message page, resets zero.
// (R5) Bit 8.14 shows partner acknowledge of successful link word receipt.
// (R6) Bit 8.12 shows partner able to act on the message.
// (R7) Bit 8.11 shows partner toggle, one when previous toggle was zero.
// (R8) Register 15h counts received packets carrying a receive error, sixteen bits.
// (R9) Enables at 1b.15 to 1b.8, writable, default zero.
// (R10) Jabber event sets self-clearing bit 1b.7.
// (R11) Receive error sets self-clearing bit 1b.6.
// (R12) New page received sets self-clearing bit 1b.5.
// (R13) Parallel detect fault sets self-clearing bit 1b.4.
// (R14) Partner ack, link down, remote fault, link up set bits 1b.3 to 1b.0.
// (R15) Bit 1f.9 picks interrupt pin polarity, zero means active low.
// (R16) Pin active while any enabled event is set; reading 1bh clears events.
// (R17) Host reads 1bh to acknowledge and writes next page before it is sent.
`timescale 1ns/1ps
`default_nettype none
module phy_nextpage_irq_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // Serial management pins
  input  wire logic                       mdc,
  input  wire logic                       mdio_in,
  output logic                            mdio_out,
  output logic                            mdio_oe,
  // Receive interface of the transceiver core
  input  wire logic                       rx_dv,
  input  wire logic                       rx_er,
  // Auto-negotiation engine
  input  wire logic                       partner_page_valid,
  input  wire logic [15:0]                partner_page_word,
  input  wire logic                       local_page_sent,
  output logic [15:0]                     local_page_word,
  // Line events
  input  wire phy_regs_pkg::link_evt_type link_evt,
  // Interrupt pin
  output logic                            intr_pin
);
  import phy_regs_pkg::*;

  mgmt_req_type req;
  logic [15:0]  rdata;
  logic [15:0]  local_q, local_d;
  logic [15:0]  partner_q, partner_d;
  logic [15:0]  tally_q, tally_d;
  logic [7:0]   en_q, en_d;
  logic [7:0]   evt_q, evt_d;
  logic         level_q, level_d;
  logic         intr_q, intr_d;
  logic         in_err_q, in_err_d;
  logic         err_start;
  logic [7:0]   evt_set;
  logic         pending;

  // Serial frame engine
  mgmt_serial #(
    .PHY_ADDR (PHY_ADDR)
  ) u_serial (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe),
    .req      (req),
    .rdata    (rdata)
  );

  // First error cycle of a packet
  assign err_start = rx_dv & rx_er & ~in_err_q;

  // Event pulses in register bit order
  assign evt_set = {link_evt.jabber, err_start, partner_page_valid, link_evt.pd_fault,
                    link_evt.lp_ack, link_evt.link_down, link_evt.remote_fault, link_evt.link_up};
  assign pending = |(evt_q & en_q);

  // Read data mux, unmapped addresses read zero
  always_comb begin
    rdata = 16'h0000;
    case (req.addr)
      LOCAL_NP_ADDR:   rdata = local_q;
      PARTNER_NP_ADDR: rdata = partner_q;
      RX_TALLY_ADDR:   rdata = tally_q;
      INTR_ADDR:       rdata = {en_q, evt_q};
      PHY_CTRL_ADDR:   rdata[INTR_LEVEL_BIT] = level_q;
      default:         rdata = 16'h0000;
    endcase
  end

  // Register next values
  always_comb begin
    local_d   = local_q;
    partner_d = partner_q;
    tally_d   = tally_q;
    en_d      = en_q;
    evt_d     = evt_q;
    level_d   = level_q;
    in_err_d  = rx_dv & (in_err_q | rx_er);
    if (req.wr && req.addr == LOCAL_NP_ADDR) begin
      local_d = (local_q & ~LOCAL_NP_WMASK) | (req.wdata & LOCAL_NP_WMASK); // [R1] [R3]
    end
    if (local_page_sent) begin
      local_d[NP_TOGL_BIT] = ~local_q[NP_TOGL_BIT];                          // [R2]
    end
    // Partner word is stored as received, its toggle coding included
    if (partner_page_valid) begin
      partner_d = partner_page_word;                                         // [R4] [R5] [R6] [R7]
    end
    // Saturate so an error flood never wraps back to a small count
    if (err_start && tally_q != RX_TALLY_MAX) begin
      tally_d = tally_q + 16'h0001;                                          // [R8]
    end
    if (req.wr && req.addr == INTR_ADDR) begin
      en_d = req.wdata[15:INTR_EN_LSB];                                      // [R9]
    end
    // Pin polarity is the only bit kept in the control register
    if (req.wr && req.addr == PHY_CTRL_ADDR) begin
      level_d = req.wdata[INTR_LEVEL_BIT];                                   // [R15]
    end
    // Read clears events; a new event in the same cycle still lands
    if (req.rd && req.addr == INTR_ADDR) begin
      evt_d = 8'h00;                                                         // [R16]
    end
    evt_d   = evt_d | evt_set;                                               // [R10] [R11] [R12] [R13] [R14]
    intr_d  = level_q ? pending : ~pending;                                  // [R15] [R16]
    if (srst) begin
      local_d   = LOCAL_NP_RESET;
      partner_d = PARTNER_NP_RESET;
      tally_d   = RX_TALLY_RESET;
      en_d      = INTR_EN_RESET;
      evt_d     = EVENT_RESET;
      level_d   = INTR_LEVEL_RESET;
      in_err_d  = 1'b0;
      intr_d    = ~INTR_LEVEL_RESET;
    end
  end

  // Register state
  always_ff @(posedge sys_clk) begin
    local_q   <= local_d;
    partner_q <= partner_d;
    tally_q   <= tally_d;
    en_q      <= en_d;
    evt_q     <= evt_d;
    level_q   <= level_d;
    intr_q    <= intr_d;
    in_err_q  <= in_err_d;
  end

  // Outputs straight from their registers
  assign local_page_word = local_q;
  assign intr_pin        = intr_q;

  // Checks on register behaviour
  property p_ack2_write;
    @(posedge sys_clk) disable iff (srst)
    req.wr && req.addr == LOCAL_NP_ADDR |=> local_q[NP_ACK2_BIT] == $past(req.wdata[NP_ACK2_BIT]);
  endproperty
  a_ack2_write: assert property (p_ack2_write) else $error("ack2 bit not written"); // [R1]

  property p_toggle_flip;
    @(posedge sys_clk) disable iff (srst)
    local_page_sent |=> local_q[NP_TOGL_BIT] != $past(local_q[NP_TOGL_BIT]);
  endproperty
  a_toggle_flip: assert property (p_toggle_flip) else $error("toggle did not flip"); // [R2]

  property p_msg_write;
    @(posedge sys_clk) disable iff (srst)
    req.wr && req.addr == LOCAL_NP_ADDR |=> local_q[NP_MSG_MSB:0] == $past(req.wdata[NP_MSG_MSB:0]);
  endproperty
  a_msg_write: assert property (p_msg_write) else $error("message field not written"); // [R3]

  property p_partner_load;
    @(posedge sys_clk) disable iff (srst)
    partner_page_valid |=> partner_q == $past(partner_page_word) ##1 1'b1;
  endproperty
  a_partner_load: assert property (p_partner_load) else $error("partner word not loaded"); // [R4] [R5] [R6] [R7]

  property p_tally_inc;
    @(posedge sys_clk) disable iff (srst)
    err_start && tally_q != RX_TALLY_MAX |=> tally_q == $past(tally_q) + 16'h0001;
  endproperty
  a_tally_inc: assert property (p_tally_inc) else $error("error tally missed a packet"); // [R8]

  property p_enable_write;
    @(posedge sys_clk) disable iff (srst)
    req.wr && req.addr == INTR_ADDR |=> en_q == $past(req.wdata[15:INTR_EN_LSB]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enables not written"); // [R9]

  property p_high_events;
    @(posedge sys_clk) disable iff (srst)
    |evt_set[7:4] |=> (evt_q[7:4] & $past(evt_set[7:4])) == $past(evt_set[7:4]);
  endproperty
  a_high_events: assert property (p_high_events) else $error("event bit not set"); // [R10] [R11] [R12] [R13]

  property p_low_events;
    @(posedge sys_clk) disable iff (srst)
    |evt_set[3:0] |=> (evt_q[3:0] & $past(evt_set[3:0])) == $past(evt_set[3:0]);
  endproperty
  a_low_events: assert property (p_low_events) else $error("low event bit not set"); // [R14]

  property p_polarity;
    @(posedge sys_clk) disable iff (srst)
    ##1 intr_pin == ($past(level_q) ? $past(pending) : !$past(pending));
  endproperty
  a_polarity: assert property (p_polarity) else $error("interrupt pin polarity wrong"); // [R15]

  property p_read_clear;
    @(posedge sys_clk) disable iff (srst)
    req.rd && req.addr == INTR_ADDR && evt_set == 8'h00 |=> evt_q == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear events"); // [R16]

  // Stability: each field moves only through its own strobe
  property p_ack2_hold;
    @(posedge sys_clk) disable iff (srst)
    !(req.wr && req.addr == LOCAL_NP_ADDR) |=> $stable(local_q[NP_ACK2_BIT]);
  endproperty
  a_ack2_hold: assert property (p_ack2_hold) else $error("ack2 bit changed without a write"); // [R1]

  property p_toggle_hold;
    @(posedge sys_clk) disable iff (srst)
    !local_page_sent |=> $stable(local_q[NP_TOGL_BIT]);
  endproperty
  a_toggle_hold: assert property (p_toggle_hold) else $error("toggle changed without a sent page"); // [R2]

  property p_msg_hold;
    @(posedge sys_clk) disable iff (srst)
    !(req.wr && req.addr == LOCAL_NP_ADDR) |=> $stable(local_q[NP_MSG_MSB:0]);
  endproperty
  a_msg_hold: assert property (p_msg_hold) else $error("message field changed without a write"); // [R3]

  property p_partner_hold;
    @(posedge sys_clk) disable iff (srst)
    !partner_page_valid |=> $stable(partner_q);
  endproperty
  a_partner_hold: assert property (p_partner_hold) else $error("partner word changed without a page"); // [R4] [R5] [R6] [R7]

  property p_tally_hold;
    @(posedge sys_clk) disable iff (srst)
    !err_start |=> $stable(tally_q);
  endproperty
  a_tally_hold: assert property (p_tally_hold) else $error("error tally moved without an error"); // [R8]

  property p_tally_sat;
    @(posedge sys_clk) disable iff (srst)
    tally_q == RX_TALLY_MAX |=> tally_q == RX_TALLY_MAX;
  endproperty
  a_tally_sat: assert property (p_tally_sat) else $error("error tally wrapped"); // [R8]

  property p_enable_hold;
    @(posedge sys_clk) disable iff (srst)
    !(req.wr && req.addr == INTR_ADDR) |=> $stable(en_q);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enables changed without a write"); // [R9]

  property p_event_cause;
    @(posedge sys_clk) disable iff (srst)
    evt_set == 8'h00 |=> (evt_q & ~$past(evt_q)) == 8'h00;
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("event bit set without a cause"); // [R10] [R11] [R12] [R13] [R14]

  property p_event_keep;
    @(posedge sys_clk) disable iff (srst)
    !(req.rd && req.addr == INTR_ADDR) |=> (evt_q & $past(evt_q)) == $past(evt_q);
  endproperty
  a_event_keep: assert property (p_event_keep) else $error("event bit lost without a read"); // [R16]

  property p_set_wins;
    @(posedge sys_clk) disable iff (srst)
    req.rd && req.addr == INTR_ADDR |=> evt_q == $past(evt_set);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event during read clear was lost"); // [R16]

  property p_level_write;
    @(posedge sys_clk) disable iff (srst)
    req.wr && req.addr == PHY_CTRL_ADDR |=> level_q == $past(req.wdata[INTR_LEVEL_BIT]);
  endproperty
  a_level_write: assert property (p_level_write) else $error("polarity bit not written"); // [R15]

  property p_level_hold;
    @(posedge sys_clk) disable iff (srst)
    !(req.wr && req.addr == PHY_CTRL_ADDR) |=> $stable(level_q);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("polarity changed without a write"); // [R15]

  // Main scenarios
  c_read_intr: cover property (@(posedge sys_clk) disable iff (srst) req.rd && req.addr == INTR_ADDR && evt_q != 8'h00);
  c_write_np: cover property (@(posedge sys_clk) disable iff (srst) req.wr && req.addr == LOCAL_NP_ADDR);
  c_irq_on: cover property (@(posedge sys_clk) disable iff (srst) pending ##2 intr_pin == level_q);
  c_tally_more: cover property (@(posedge sys_clk) disable iff (srst) err_start && tally_q != RX_TALLY_RESET);
  c_active_high: cover property (@(posedge sys_clk) disable iff (srst) level_q && pending);

endmodule // phy_nextpage_irq_regs
`default_nettype wire

// ===== test/mgmt_host.sv
`timescale 1ns/1ps
`default_nettype none
// Station management host: makes MDC only within frames, drives or releases MDIO
module mgmt_host #(
  parameter logic [4:0] ADDR = 5'h01
) (
  // Clock
  input  wire logic sys_clk,
  // Serial management pins
  output logic      mdc,
  output logic      host_d,
  output logic      host_oe,
  input  wire logic mdio_line
);
  import phy_regs_pkg::*;

  initial begin
    mdc = 1'b0;
    host_d = 1'b1;
    host_oe = 1'b0;
  end

  // One MDC period of 8 cycles; the line is sampled just before the rise
  task automatic tick(input logic b, input logic drv, output logic s);
    @(negedge sys_clk);
    mdc = 1'b0;
    host_d = b;
    host_oe = drv;
    repeat (4) @(negedge sys_clk);
    s = mdio_line;
    mdc = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask

  // Whole frame to any station address, so refused frames can be sent as well
  task automatic xfer_at(input logic [4:0] pa, input logic [1:0] op, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic        s;
    f = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      tick(f[i], (op == OP_WRITE) || (i > 17), s);
      if (i < 16) begin
        rd[i] = s;
      end
    end
    host_oe = 1'b0;
    repeat (8) @(negedge sys_clk);
  endtask

  // Whole frame with its own preamble; events are acknowledged by reading
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                      output logic [15:0] rd);
    xfer_at(ADDR, op, ra, wd, rd);
  endtask
endmodule // mgmt_host
`default_nettype wire

// ===== test/tb_phy_nextpage_irq_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_phy_nextpage_irq_regs;
  import phy_regs_pkg::*;

  logic         sys_clk;
  logic         srst;
  logic         rx_dv;
  logic         rx_er;
  logic         partner_page_valid;
  logic [15:0]  partner_page_word;
  logic         local_page_sent;
  link_evt_type link_evt;
  logic         mdio_out;
  logic         mdio_oe;
  logic [15:0]  local_page_word;
  logic         intr_pin;
  logic         mdc;
  logic         host_d;
  logic         host_oe;
  logic         mdio_line;
  int           n_fail;
  int           checks_done;

  // Pulled-up management line
  assign mdio_line = mdio_oe ? mdio_out : (host_oe ? host_d : 1'b1);

  phy_nextpage_irq_regs dut (
    .sys_clk(sys_clk), .srst(srst), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .rx_dv(rx_dv), .rx_er(rx_er), .partner_page_valid(partner_page_valid),
    .partner_page_word(partner_page_word), .local_page_sent(local_page_sent),
    .local_page_word(local_page_word), .link_evt(link_evt), .intr_pin(intr_pin)
  );
  mgmt_host host (.sys_clk(sys_clk), .mdc(mdc), .host_d(host_d), .host_oe(host_oe), .mdio_line(mdio_line));

  // Clock generator
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] x;
    host.xfer(OP_WRITE, a, d, x);
  endtask

  task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    host.xfer(OP_READ, a, 16'h0000, d);
    chk(nm, e, d);
  endtask

  task automatic pin(input string nm, input logic e);
    chk(nm, {15'h0000, e}, {15'h0000, intr_pin});
  endtask

  // One-cycle strobe on the chosen input, then let it settle
  task automatic evt(input link_evt_type e, input logic pv, input logic ls);
    @(negedge sys_clk);
    link_evt = e;
    partner_page_valid = pv;
    local_page_sent = ls;
    @(negedge sys_clk);
    link_evt = '0;
    partner_page_valid = 1'b0;
    local_page_sent = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  // Packet with two error spans, which count as one
  task automatic pkt(input logic err);
    @(negedge sys_clk);
    rx_dv = 1'b1;
    rx_er = err;
    repeat (2) @(negedge sys_clk);
    rx_er = 1'b0;
    @(negedge sys_clk);
    rx_er = err;
    @(negedge sys_clk);
    rx_er = 1'b0;
    rx_dv = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask

  task automatic t_reset;
    chk("page_out", 16'h2001, local_page_word);
    pin("pin_idle", 1'b1);
    rchk("np_local", LOCAL_NP_ADDR, 16'h2001);
    rchk("np_partner", PARTNER_NP_ADDR, 16'h0000);
    rchk("tally", RX_TALLY_ADDR, 16'h0000);
    rchk("intr_reg", INTR_ADDR, 16'h0000);
    rchk("unmapped", 5'h03, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_local;
    wr(LOCAL_NP_ADDR, 16'hFFFF);
    rchk("np_local", LOCAL_NP_ADDR, 16'hB7FF);
    chk("page_out", 16'hB7FF, local_page_word);
    evt('0, 1'b0, 1'b1);
    rchk("toggle", LOCAL_NP_ADDR, 16'hBFFF);
    wr(LOCAL_NP_ADDR, 16'h0000);
    rchk("np_clear", LOCAL_NP_ADDR, 16'h0800);
    $display("test local page done");
  endtask

  // Frames for another station address: no write lands, the line is never driven
  task automatic t_refused;
    logic [15:0] d;
    host.xfer_at(5'h1E, OP_WRITE, LOCAL_NP_ADDR, 16'hFFFF, d);
    rchk("np_kept", LOCAL_NP_ADDR, 16'h0800);
    host.xfer_at(5'h1E, OP_READ, LOCAL_NP_ADDR, 16'h0000, d);
    chk("no_drive", 16'hFFFF, d);
    chk("oe_idle", 16'h0000, {15'h0000, mdio_oe});
    $display("test refused frames done");
  endtask

  task automatic t_partner;
    logic [15:0] w [2];
    w = '{16'hF800, 16'h5123};
    foreach (w[i]) begin
      partner_page_word = w[i];
      evt('0, 1'b1, 1'b0);
      rchk("np_partner", PARTNER_NP_ADDR, w[i]);
    end
    wr(PARTNER_NP_ADDR, 16'h0000);
    rchk("np_ro", PARTNER_NP_ADDR, 16'h5123);
    rchk("page_evt", INTR_ADDR, 16'h0020);
    rchk("self_clear", INTR_ADDR, 16'h0000);
    $display("test partner page done");
  endtask

  task automatic t_tally;
    pkt(1'b1);
    pkt(1'b0);
    pkt(1'b1);
    rchk("tally", RX_TALLY_ADDR, 16'h0002);
    rchk("rx_err_evt", INTR_ADDR, 16'h0040);
    $display("test receive error done");
  endtask

  task automatic t_events;
    int b;
    for (int i = 0; i < 6; i++) begin
      b = (i == 5) ? 7 : ((i == 4) ? 4 : i);
      evt(link_evt_type'(6'h01 << i), 1'b0, 1'b0);
      pin("pin_masked", 1'b1);
      wr(INTR_ADDR, 16'h0100 << b);
      pin("pin_active", 1'b0);
      rchk("event", INTR_ADDR, 16'h0101 << b);
      pin("pin_cleared", 1'b1);
    end
    wr(PHY_CTRL_ADDR, 16'h0200);
    pin("pin_high_idle", 1'b0);
    evt(6'h20, 1'b0, 1'b0);
    pin("pin_high_on", 1'b1);
    rchk("polarity", PHY_CTRL_ADDR, 16'h0200);
    rchk("jabber", INTR_ADDR, 16'h8080);
    pin("pin_high_off", 1'b0);
    $display("test events done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond some forty frames of 520 cycles
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    conclude;
  end

  // Main sequence
  initial begin
    n_fail = 0;
    checks_done = 0;
    srst = 1'b1;
    rx_dv = 1'b0;
    rx_er = 1'b0;
    partner_page_valid = 1'b0;
    partner_page_word = 16'h0000;
    local_page_sent = 1'b0;
    link_evt = '0;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_reset;
    t_local;
    t_refused;
    t_partner;
    t_tally;
    t_events;
    conclude;
  end
endmodule // tb_phy_nextpage_irq_regs
`default_nettype wire
